/* ctr_timer.sv */
// dual prescaled counter/timer with register port and interrupt
//
// How it works
// RL1 - two 8-bit down counters, each with own 6-bit prescaler
// RL2 - first prescaler internal clock only; second internal or external
// RL3 - prescaler divides source by 1 to 64, zero meaning 64
// RL4 - counter decrements loaded value, 1 to 256, zero meaning 256
// RL5 - counter and prescaler both ending raise that counter's request
// RL6 - software starts, stops, resumes, and restarts from loaded value
// RL7 - single pass halts at zero; continuous reloads and keeps going
// RL8 - counter reads never disturb it; prescalers read as zero
// RL9 - second source is core clock over four or input pin
// RL10 - input pin is clock, retriggerable, one-shot trigger, or gate
// RL11 - output pin shows toggle of either counter or clock when enabled
// RL12 - cascade makes first counter's end step the second
// RL13 - idle stops cpu clock; timers run; enabled timer request wakes
// RL14 - oscillator-off sleep freezes timers until reset only
// RL15 - first counter end of count is offered as baud tick
// RL16 - requests stay latched until cleared by writing one
// RL17 - continuous mode reloads prescaler and counter on end cycle
//
// Added by the designer: strobed register access and the address map.
`include "ctr_timer_consts.svh"
module ctr_timer
  import ctr_timer_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  input  wire logic        timer_input_pin_i,
  output logic             timer_output_pin_o,
  output logic             timer_output_oe_o,
  output logic             first_timer_request_o,
  output logic             second_timer_request_o,
  output logic             irq_o,
  output logic             baud_tick_o,
  output logic             cpu_clk_en_o
);
  import ctr_timer_pkg::*;

  // ***************************************************
  // reset release and state
  // ***************************************************
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // all top-level state except the reset synchronizer in one struct
  typedef struct packed {
    logic [7:0] ctrl;      // 0 st0,1 st1,2 ld0,3 ld1,4 cont0,5 cont1,6 ext1,7 cascade
    logic [7:0] mode;      // 1:0 pin mode, 3:2 out src, 4 out en
    logic [5:0] pre0;
    logic [7:0] cnt0;
    logic [5:0] pre1;
    logic [7:0] cnt1;
    logic [1:0] stat;
    logic [1:0] mask;
    pwr_state_t pwr;
    logic [2:0] pin_sync;
    logic [1:0] div4;
    logic       pin_prev;
    logic       trig_used;
    logic       timer_output_signal;
    logic [7:0] rdata;
    logic       req0;
    logic       req1;
    logic       irq;
    logic       baud;
    logic       cpu_en;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;
  reg_req_t   req;

  logic       tick1;
  logic       pin_lvl;
  logic       pin_rise;
  logic       run_gate;
  logic       frozen;
  logic       s0, p0, s1, p1, ld0, ld1, trig;
  logic [7:0] cv0, cv1;
  logic       r0, r1, e0, e1;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ***************************************************
  // channel control decode
  // ***************************************************
  // sleep gates both counter channels; only reset leaves it
  assign frozen   = (st_ff.pwr == PWR_OFF);                          // RL14
  // second and third sync stages agree before a pin change counts
  assign pin_lvl  = st_ff.pin_sync[2];
  assign pin_rise = (st_ff.pin_sync[1] == st_ff.pin_sync[2]) && pin_lvl && !st_ff.pin_prev;
  // the one-shot trigger may fire only once per control register write
  assign trig     = st_ff.ctrl[6] ? 1'b0 :
                    (st_ff.mode[1:0] == `TIN_TRIG_R  && pin_rise) ||
                    (st_ff.mode[1:0] == `TIN_TRIG_NR && pin_rise && !st_ff.trig_used); // RL10
  assign run_gate = (st_ff.mode[1:0] != `TIN_GATE) || st_ff.ctrl[6] || pin_lvl;

  // second source: cascade, pin clock, or core over four
  always_comb
  begin
    if (st_ff.ctrl[7])
      tick1 = e0;                                                    // RL12
    else if (st_ff.ctrl[6])
      tick1 = pin_rise;                                              // RL9
    else
      tick1 = (st_ff.div4 == `DIV4_LAST) && run_gate;                // RL9
  end

  assign s0  = req.wr && req.addr == `OFF_CTRL && req.wdata[0];
  assign p0  = req.wr && req.addr == `OFF_CTRL && !req.wdata[0];
  assign s1  = (req.wr && req.addr == `OFF_CTRL && req.wdata[1]) || trig;
  assign p1  = req.wr && req.addr == `OFF_CTRL && !req.wdata[1] && !trig;
  assign ld0 = req.wr && req.addr == `OFF_CTRL && req.wdata[2];     // RL6
  assign ld1 = (req.wr && req.addr == `OFF_CTRL && req.wdata[3]) || trig;

  // ***************************************************
  // the two channels
  // ***************************************************
  // first channel ticks on every core cycle: internal clock only
  ctr_chan u_ch0 (                                                   // RL1
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .ce_i      (ce_i && !frozen),
    .tick_i    (1'b1),                                               // RL2
    .start_i   (s0),
    .stop_i    (p0),
    .load_i    (ld0),
    .cont_i    (st_ff.ctrl[4]),
    .pre_val_i (st_ff.pre0),
    .cnt_val_i (st_ff.cnt0),
    .cnt_o     (cv0),
    .run_o     (r0),
    .eoc_o     (e0)
  );

  ctr_chan u_ch1 (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .ce_i      (ce_i && !frozen),
    .tick_i    (tick1),
    .start_i   (s1),
    .stop_i    (p1),
    .load_i    (ld1),
    .cont_i    (st_ff.ctrl[5]),
    .pre_val_i (st_ff.pre1),
    .cnt_val_i (st_ff.cnt1),
    .cnt_o     (cv1),
    .run_o     (r1),
    .eoc_o     (e1)
  );

  // ***************************************************
  // next state
  // ***************************************************
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.pin_sync = {st_ff.pin_sync[1:0], timer_input_pin_i};
    if (st_ff.pin_sync[1] == st_ff.pin_sync[2])
      nxt_st.pin_prev = pin_lvl;
    nxt_st.div4     = st_ff.div4 + 2'h1;
    // register writes; control start/load bits are strobes
    if (req.wr)
    begin
      case (req.addr)
        `OFF_CTRL:  nxt_st.ctrl = req.wdata;
        `OFF_MODE:  nxt_st.mode = req.wdata;
        `OFF_PRE0:  nxt_st.pre0 = req.wdata[5:0];
        `OFF_CNT0:  nxt_st.cnt0 = req.wdata;
        `OFF_PRE1:  nxt_st.pre1 = req.wdata[5:0];
        `OFF_CNT1:  nxt_st.cnt1 = req.wdata;
        `OFF_STAT:  nxt_st.stat = st_ff.stat & ~req.wdata[1:0];      // RL16
        `OFF_MASK:  nxt_st.mask = req.wdata[1:0];
        `OFF_POWER:
        begin
          if (req.wdata[1])
            nxt_st.pwr = PWR_OFF;
          else if (req.wdata[0])
            nxt_st.pwr = PWR_IDLE;
        end
        default:    nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    if (req.wr && req.addr == `OFF_CTRL)
      nxt_st.trig_used = 1'b0;
    if (trig)
      nxt_st.trig_used = 1'b1;
    // events set sticky flags; set beats a same-cycle clear
    if (e0)
      nxt_st.stat[0] = 1'b1;                                         // RL5
    if (e1)
      nxt_st.stat[1] = 1'b1;                                         // RL5
    // enabled timer request ends idle
    if (st_ff.pwr == PWR_IDLE && |(st_ff.stat & st_ff.mask))
      nxt_st.pwr = PWR_RUN;                                          // RL13
    if (frozen)
      nxt_st.pwr = PWR_OFF;                                          // RL14
    nxt_st.cpu_en = (nxt_st.pwr == PWR_RUN);                         // RL13
    // output pin toggles on chosen end of count or follows the core clock over four
    case (st_ff.mode[3:2])
      `TIMER_OUTPUT_SIGNAL_T0:  nxt_st.timer_output_signal = st_ff.timer_output_signal ^ e0;                      // RL11
      `TIMER_OUTPUT_SIGNAL_T1:  nxt_st.timer_output_signal = st_ff.timer_output_signal ^ e1;
      `TIMER_OUTPUT_SIGNAL_CLK: nxt_st.timer_output_signal = st_ff.div4[1];
      default:   nxt_st.timer_output_signal = st_ff.timer_output_signal;
    endcase
    // read data valid the cycle after the strobe only
    nxt_st.rdata = `RST_BYTE;
    if (req.rd)
    begin
      case (req.addr)
        `OFF_CTRL:  nxt_st.rdata = {st_ff.ctrl[7:4], 2'b00, r1, r0};
        `OFF_MODE:  nxt_st.rdata = st_ff.mode;
        `OFF_CNT0:  nxt_st.rdata = cv0;                              // RL8
        `OFF_CNT1:  nxt_st.rdata = cv1;                              // RL8
        `OFF_STAT:  nxt_st.rdata = {6'h00, st_ff.stat};
        `OFF_MASK:  nxt_st.rdata = {6'h00, st_ff.mask};
        `OFF_POWER: nxt_st.rdata = {5'h00, st_ff.pwr};
        default:    nxt_st.rdata = `RST_BYTE;                        // RL8
      endcase
    end
    nxt_st.req0 = nxt_st.stat[0];                                    // RL16
    nxt_st.req1 = nxt_st.stat[1];
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);
    nxt_st.baud = e0;                                                // RL15
  end

  // ***************************************************
  // state register
  // ***************************************************
  // sleep does not gate this register; only the two channels freeze
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff      <= '0;
      st_ff.pwr  <= PWR_RUN;
      st_ff.pre0 <= `ZERO_PRE;
    end
    else if (ce_i)
      st_ff <= nxt_st;
  end

  assign rdata_o                = st_ff.rdata;
  assign timer_output_pin_o     = st_ff.timer_output_signal;
  assign timer_output_oe_o      = st_ff.mode[4];                     // RL11
  assign first_timer_request_o  = st_ff.req0;
  assign second_timer_request_o = st_ff.req1;
  assign irq_o                  = st_ff.irq;
  assign baud_tick_o            = st_ff.baud;
  assign cpu_clk_en_o           = st_ff.cpu_en;

  AST_FLAG_SET_WINS : assert property (@(posedge core_clk_i) disable iff (!rst_n) // RL16
    (ce_i && e0) |=> st_ff.stat[0])
    else $error("timer zero flag lost");
  AST_REQ_FOLLOWS : assert property (@(posedge core_clk_i) disable iff (!rst_n) // RL5
    (ce_i && e1) |=> second_timer_request_o)
    else $error("second request not raised");
  AST_WAKE : assert property (@(posedge core_clk_i) disable iff (!rst_n) // RL13
    (ce_i && st_ff.pwr == PWR_IDLE && |(st_ff.stat & st_ff.mask)) |=> cpu_clk_en_o)
    else $error("idle not left on request");
  AST_SLEEP_STAYS : assert property (@(posedge core_clk_i) disable iff (!rst_n) // RL14
    (st_ff.pwr == PWR_OFF) |=> (st_ff.pwr == PWR_OFF && !cpu_clk_en_o))
    else $error("sleep left without reset");
  AST_CNT_READ : assert property (@(posedge core_clk_i) disable iff (!rst_n) // RL8
    (ce_i && rd_i && addr_i == `OFF_CNT0) |=> (rdata_o == $past(cv0)))
    else $error("counter read wrong");
endmodule : ctr_timer

/* ctr_timer_consts.svh */
// constants for the dual prescaled counter/timer
`ifndef CTR_TIMER_CONSTS_SVH
`define CTR_TIMER_CONSTS_SVH
`define ADDR_W        4
`define DATA_W        8
`define OFF_CTRL      4'h0
`define OFF_MODE      4'h1
`define OFF_PRE0      4'h2
`define OFF_CNT0      4'h3
`define OFF_PRE1      4'h4
`define OFF_CNT1      4'h5
`define OFF_STAT      4'h6
`define OFF_MASK      4'h7
`define OFF_POWER     4'h8
`define PRE_W         6
`define CNT_W         8
`define DIV4_LAST     2'h3
`define ZERO_CNT      8'h00
`define ONE_CNT       8'h01
`define ZERO_PRE      6'h00
`define ONE_PRE       6'h01
`define RST_BYTE      8'h00
`define TIN_CLOCK     2'h0
`define TIN_GATE      2'h1
`define TIN_TRIG_NR   2'h2
`define TIN_TRIG_R    2'h3
`define TIMER_OUTPUT_SIGNAL_T0       2'h0
`define TIMER_OUTPUT_SIGNAL_T1       2'h1
`define TIMER_OUTPUT_SIGNAL_CLK      2'h2
`endif

/* ctr_timer_pkg.sv */
// types shared by the counter/timer block
package ctr_timer_pkg;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  // power state of the core clock
  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_IDLE = 3'b010,
    PWR_OFF  = 3'b100
  } pwr_state_t;
  // one counter channel state
  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [7:0] cnt;
    logic       run;
    logic       eoc;
  } chan_state_t;
endpackage : ctr_timer_pkg

/* ctr_chan.sv */
// one prescaled 8-bit down counter channel
`include "ctr_timer_consts.svh"
module ctr_chan
  import ctr_timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        tick_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        load_i,
  input  wire logic        cont_i,
  input  wire logic [5:0]  pre_val_i,
  input  wire logic [7:0]  cnt_val_i,
  output logic [7:0]       cnt_o,
  output logic             run_o,
  output logic             eoc_o
);
  chan_state_t st_ff;
  chan_state_t nxt_st;

  // prescale tick then count; end of count when both wrap
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.eoc = 1'b0;
    if (start_i)
      nxt_st.run = 1'b1;
    if (stop_i)
      nxt_st.run = 1'b0;
    if (load_i)
    begin
      nxt_st.pre_cnt = pre_val_i;        // RL6
      nxt_st.cnt     = cnt_val_i;
    end
    else if (st_ff.run && tick_i)
    begin
      // prescale value 0 means divide by 64
      if (st_ff.pre_cnt == `ONE_PRE)
      begin
        nxt_st.pre_cnt = pre_val_i;      // RL3
        // count value 0 means 256 steps
        if (st_ff.cnt == `ONE_CNT)
        begin
          nxt_st.eoc = 1'b1;             // RL5
          if (cont_i)
            nxt_st.cnt = cnt_val_i;      // RL17
          else
          begin
            nxt_st.cnt = `ZERO_CNT;      // RL7
            nxt_st.run = 1'b0;
          end
        end
        else
          nxt_st.cnt = st_ff.cnt - `ONE_CNT; // RL4
      end
      else
        nxt_st.pre_cnt = st_ff.pre_cnt - `ONE_PRE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_ff <= '0;
    else if (ce_i)
      st_ff <= nxt_st;
  end

  assign cnt_o = st_ff.cnt;
  assign run_o = st_ff.run;
  assign eoc_o = st_ff.eoc;

  AST_SINGLE_STOPS : assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL7
    (ce_i && st_ff.run && tick_i && !load_i && !cont_i && !stop_i
     && st_ff.pre_cnt == `ONE_PRE && st_ff.cnt == `ONE_CNT)
    |=> (!st_ff.run && st_ff.eoc))
    else $error("single pass did not halt at zero");
  AST_CONT_RELOAD : assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL17
    (ce_i && st_ff.run && tick_i && !load_i && cont_i
     && st_ff.pre_cnt == `ONE_PRE && st_ff.cnt == `ONE_CNT)
    |=> (st_ff.cnt == $past(cnt_val_i) && st_ff.pre_cnt == $past(pre_val_i)))
    else $error("continuous reload missed");
  AST_HOLD_STOPPED : assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
    (!st_ff.run && !load_i) |=> $stable(st_ff.cnt))
    else $error("stopped counter moved");
endmodule : ctr_chan

/* tin_source.sv */
// timer input pin source and output pin load for the counter/timer bench
module tin_source
(
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  input  wire logic       out_pin_i,
  output logic            pin_o,
  output int              toggles_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   k;
  logic last;
  // ***********************************
  // external clock and pin load
  // ***********************************
  initial
  begin
    pin_o     = 1'b0;
    toggles_o = 0;
    k         = 0;
    last      = 1'b0;
  end
  // clock runs only while asked; it rests low so no stray edge is counted
  always @(posedge clk_i)
  begin
    k <= (run_i && k + 1 < int'(half_i)) ? k + 1 : 0;
    if (!run_i)
      pin_o <= 1'b0;
    else if (k + 1 >= int'(half_i))
      pin_o <= ~pin_o;
    last <= out_pin_i;
    if (out_pin_i !== last)
      toggles_o <= toggles_o + 1;
  end
endmodule : tin_source

/* ctr_timer_bench.sv */
// self-checking bench for the dual prescaled counter/timer
`include "ctr_timer_consts.svh"
module ctr_timer_bench;
  import ctr_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_i, rst_n_i, ce_i, wr_i, rd_i, pin_in, src_run;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, v, w, p, c;
  logic       pin_o, oe_o, req0, req1, irq_o, baud_o, cpu_en;
  int         n_fail, checks_done, togg, t0, t, cyc, lastb, gap, nb;
  ctr_timer DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_input_pin_i(pin_in), .timer_output_pin_o(pin_o), .timer_output_oe_o(oe_o),
    .first_timer_request_o(req0), .second_timer_request_o(req1), .irq_o(irq_o),
    .baud_tick_o(baud_o), .cpu_clk_en_o(cpu_en));
  tin_source SRC (.clk_i(core_clk_i), .run_i(src_run), .half_i(4'h4), .out_pin_i(pin_o),
    .pin_o(pin_in), .toggles_o(togg));
  // ***********************************
  // clock, watchers and tasks
  // ***********************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // gap between baud ticks shows whether reload loses a cycle
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (baud_o === 1'b1)
    begin
      gap   <= cyc - lastb;
      lastb <= cyc;
      nb    <= nb + 1;
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_in
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdc
  // bounded wait on a request (0, 1) or the cpu clock enable (2)
  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? req0 : (sel == 1) ? req1 : cpu_en) !== 1'b1)
    begin
      @(posedge core_clk_i);
      #1 n++;
      if (n > lim)
      begin
        n_fail++;
        $display("[ERR] %0t wait timed out", $time);
        conclude();
      end
    end
  endtask : wait_for
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask : do_reset
  task automatic clear_all;
    wr(`OFF_CTRL, 8'h00);
    wr(`OFF_STAT, 8'h03);
  endtask : clear_all
  // cycles to end of count; a zero field stands for its full range
  function automatic int ticks(input logic [7:0] pv, input logic [7:0] cv, input int dv);
    return ((pv[5:0] == 6'h00) ? 64 : int'(pv[5:0])) * ((cv == 8'h00) ? 256 : int'(cv)) * dv;
  endfunction : ticks
  // single pass run of one counter, timed from the start write
  task automatic timed(input int sel, input logic [7:0] pv, input logic [7:0] cv, output int n);
    wr(sel ? `OFF_PRE1 : `OFF_PRE0, pv);
    wr(sel ? `OFF_CNT1 : `OFF_CNT0, cv);
    wr(`OFF_CTRL, sel ? 8'h0A : 8'h05);
    wait_for(sel, 20000, n);
  endtask : timed
  // ***********************************
  // main sequence
  // ***********************************
  initial
  begin
    {rst_n_i, wr_i, rd_i, src_run} = 4'h0;
    ce_i    = 1'b1;
    addr_i  = 4'h0;
    wdata_i = 8'h00;
    void'($urandom(19));
    do_reset();
    chk(8'(cpu_en), 8'h01);
    rdc(`OFF_CTRL, 8'h00);
    rdc(`OFF_STAT, 8'h00);
    wr(`OFF_PRE0, 8'h2A);
    rdc(`OFF_PRE0, 8'h00);
    for (int a = 9; a < 16; a++)
    begin
      wr(4'(a), 8'($urandom));
      rdc(4'(a), 8'h00);
    end
    // counter0 corners then random, counter1 on core clock over four
    for (int i = 0; i < 5; i++)
    begin
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'($urandom_range(6, 1));
      c = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'($urandom_range(9, 1));
      t0 = nb;
      timed(i / 3, p, c, t);
      chk_in(t, ticks(p, c, (i < 3) ? 1 : 4) - 2, ticks(p, c, (i < 3) ? 1 : 4) + 6);
      rdc(`OFF_CTRL, 8'h00);
      chk_in(nb - t0, (i < 3) ? 1 : 0, (i < 3) ? 1 : 0);
      repeat (5) @(posedge core_clk_i);
      chk(8'({req1, req0}), (i < 3) ? 8'h01 : 8'h02);
      chk(8'(irq_o), 8'h00);
      wr(`OFF_MASK, 8'h03);
      #1 chk(8'(irq_o), 8'h01);
      wr(`OFF_STAT, 8'h03);
      repeat (2) @(posedge core_clk_i);
      #1 chk(8'({irq_o, req1, req0}), 8'h00);
      wr(`OFF_MASK, 8'h00);
    end
    // continuous counter0 driving the output pin
    wr(`OFF_MODE, 8'h10);
    #1 chk(8'(oe_o), 8'h01);
    wr(`OFF_PRE0, 8'h02);
    wr(`OFF_CNT0, 8'h05);
    wr(`OFF_CTRL, 8'h15);
    t0 = togg;
    repeat (35) @(posedge core_clk_i);
    chk_in(gap, 10, 10);
    chk_in(togg - t0, 2, 4);
    // stop, resume, restart
    wr(`OFF_PRE0, 8'h00);
    wr(`OFF_CNT0, 8'hC8);
    wr(`OFF_CTRL, 8'h15);
    repeat (300) @(posedge core_clk_i);
    wr(`OFF_CTRL, 8'h10);
    rd(`OFF_CNT0, v);
    chk_in(int'(v), 193, 198);
    repeat (100) @(posedge core_clk_i);
    rd(`OFF_CNT0, w);
    chk(w, v);
    wr(`OFF_CTRL, 8'h11);
    rd(`OFF_CNT0, w);
    chk_in(int'(w), int'(v) - 1, int'(v));
    wr(`OFF_CTRL, 8'h15);
    rd(`OFF_CNT0, w);
    chk_in(int'(w), 199, 200);
    clear_all();
    // counter1 on the external clock from the pin
    src_run <= 1'b1;
    wr(`OFF_PRE1, 8'h01);
    wr(`OFF_CNT1, 8'h04);
    wr(`OFF_CTRL, 8'h4A);
    wait_for(1, 200, t);
    chk_in(t, 24, 48);
    src_run <= 1'b0;
    clear_all();
    // one-shot trigger fires once per control write; pin shows counter1 ends
    wr(`OFF_MODE, 8'h16);
    wr(`OFF_PRE1, 8'h01);
    wr(`OFF_CNT1, 8'h01);
    wr(`OFF_CTRL, 8'h00);
    t0 = togg;
    src_run <= 1'b1;
    wait_for(1, 60, t);
    wr(`OFF_STAT, 8'h03);
    repeat (40) @(posedge core_clk_i);
    chk(8'({req1, 7'(togg - t0)}), 8'h01);
    // retriggerable trigger fires again on later rises
    wr(`OFF_MODE, 8'h13);
    wait_for(1, 60, t);
    chk_in(t, 0, 60);
    src_run <= 1'b0;
    clear_all();
    // gate held low stops counter1; pin carries the divided core clock
    wr(`OFF_MODE, 8'h19);
    wr(`OFF_CNT1, 8'h03);
    wr(`OFF_CTRL, 8'h0A);
    t0 = togg;
    repeat (40) @(posedge core_clk_i);
    rdc(`OFF_CNT1, 8'h03);
    chk_in(togg - t0, 18, 23);
    clear_all();
    wr(`OFF_MODE, 8'h00);
    // cascade: counter0 end steps counter1
    wr(`OFF_PRE0, 8'h01);
    wr(`OFF_CNT0, 8'h02);
    wr(`OFF_PRE1, 8'h01);
    wr(`OFF_CNT1, 8'h03);
    wr(`OFF_CTRL, 8'h9F);
    wait_for(1, 100, t);
    chk_in(t, 4, 14);
    clear_all();
    // idle: timer keeps counting and its enabled request wakes the cpu
    wr(`OFF_MASK, 8'h01);
    wr(`OFF_PRE0, 8'h01);
    wr(`OFF_CNT0, 8'h14);
    wr(`OFF_CTRL, 8'h05);
    wr(`OFF_POWER, 8'h01);
    repeat (2) @(posedge core_clk_i);
    #1 chk(8'(cpu_en), 8'h00);
    wait_for(2, 60, t);
    chk(8'(req0), 8'h01);
    clear_all();
    // sleep freezes the timer until reset
    timed(0, 8'h01, 8'h01, t);
    wr(`OFF_STAT, 8'h03);
    wr(`OFF_CNT0, 8'h0A);
    wr(`OFF_CTRL, 8'h05);
    wr(`OFF_POWER, 8'h02);
    repeat (60) @(posedge core_clk_i);
    #1 chk(8'({cpu_en, req0}), 8'h00);
    do_reset();
    chk(8'(cpu_en), 8'h01);
    conclude();
  end
endmodule : ctr_timer_bench
